//--- irq_pending_pkg.sv
// package: offsets, bit positions and source widths for the raw pending map
package irq_pending_pkg;

	// register map (byte addresses, word aligned)
	localparam logic [31:0] RAW_PENDING_ADDR = 32'h40d00010;
	localparam logic [31:0] RAW_PENDING_RESET = 32'h00000000;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
	// reserved bits 16:15 and 7:0 of the pending register, always read as zero
	localparam logic [31:0] RESERVED_BITS = 32'h000180ff;

	// pending bit positions
	localparam int BIT_ALARM = 31;
	localparam int BIT_TICK = 30;
	localparam int BIT_TIMER0 = 26;
	localparam int BIT_DMA = 25;
	localparam int BIT_SSP = 24;
	localparam int BIT_CARD = 23;
	localparam int BIT_FULL_FUNCTION_UART = 22;
	localparam int BIT_BLUETOOTH_UART = 21;
	localparam int BIT_STANDARD_UART = 20;
	localparam int BIT_INFRARED = 19;
	localparam int BIT_TWO_WIRE = 18;
	localparam int BIT_DISPLAY = 17;
	localparam int BIT_AUDIO = 14;
	localparam int BIT_SOUND = 13;
	localparam int BIT_PERF = 12;
	localparam int BIT_USB = 11;
	localparam int BIT_UPPER_PINS = 10;
	localparam int BIT_PIN1 = 9;
	localparam int BIT_PIN0 = 8;

	// second-level source counts per unit
	localparam int N_TIMER = 4;
	localparam int N_DMA = 16;
	localparam int N_SSP = 3;
	localparam int N_CARD = 9;
	localparam int N_FULL_FUNCTION_UART = 5;
	localparam int N_BLUETOOTH_UART = 5;
	localparam int N_STANDARD_UART = 4;
	localparam int N_INFRARED = 6;
	localparam int N_TWO_WIRE = 6;
	localparam int N_DISPLAY = 15;
	localparam int N_AUDIO = 10;
	localparam int N_SOUND = 5;
	localparam int N_USB = 7;
	localparam int N_UPPER_PINS = 79;

	// bundle of every second-level request line
	typedef struct packed {
		logic alarm;
		logic tick;
		logic [N_TIMER-1:0] timer_match;
		logic [N_DMA-1:0] dma;
		logic [N_SSP-1:0] sync_serial_port;
		logic [N_CARD-1:0] card;
		logic [N_FULL_FUNCTION_UART-1:0] full_function_uart;
		logic [N_BLUETOOTH_UART-1:0] bluetooth_uart;
		logic [N_STANDARD_UART-1:0] standard_uart;
		logic [N_INFRARED-1:0] infrared;
		logic [N_TWO_WIRE-1:0] two_wire;
		logic [N_DISPLAY-1:0] display;
		logic [N_AUDIO-1:0] audio;
		logic [N_SOUND-1:0] sound;
		logic perf;
		logic [N_USB-1:0] usb;
		logic [N_UPPER_PINS-1:0] upper_pins;
		logic pin1;
		logic pin0;
	} source_lines_type;

	// wishbone request bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
	} wb_req_type;

endpackage : irq_pending_pkg

//--- unit_request_or.sv
// module: one unit's second-level status lines merged into one request
`timescale 1ns/1ps
`default_nettype none
module unit_request_or #(
	parameter int WIDTH = 1
) (
	input wire logic [WIDTH-1:0] status_i,
	output logic request_o
);

	// any status bit still set keeps the unit requesting
	assign request_o = |status_i;

endmodule : unit_request_or
`default_nettype wire

//--- irq_pending_map.sv
// module: raw (unmasked) interrupt pending register on a wishbone slave
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - rtc alarm bit 31, tick bit 30
// - timer matches 3..0 on bits 29..26
// - bit 25 ors sixteen dma channels
// - bits 24..21: ssp, card, two uarts
// - bit 20 follows standard uart requests
// - bit 19 follows infrared port requests
// - bit 18 follows two-wire unit requests
// - bit 17 ors fifteen display sources
// - bit 14 follows audio codec unit
// - bit 13 follows sound serial unit
// - bit 12 follows performance monitor
// - bit 11 follows usb unit
// - bit 10 ors pin edges 80..2
// - bit 9 is pin 1 edge
// - bit 8 is pin 0 edge
// - pending ignores mask settings
// - bit clears only when unit idle
module irq_pending_map (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire irq_pending_pkg::source_lines_type src_i,
	input wire irq_pending_pkg::wb_req_type wb_req_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [31:0] raw_pending_reg_o
);

	logic [31:0] raw_pending_reg_q;
	logic [31:0] raw_pending_reg_d;
	logic [31:0] wb_dat_q;
	logic wb_ack_q;
	logic dma_request_pending;
	logic sync_serial_pending;
	logic card_pending;
	logic fullfunc_uart_pending;
	logic bt_uart_pending;
	logic standard_uart_pending;
	logic infrared_pending;
	logic two_wire_pending;
	logic display_pending;
	logic audio_codec_pending;
	logic sound_serial_pending;
	logic usb_pending;
	logic upper_pins_edge_pending;

	// per-unit merge; each unit's own status register says which source
	unit_request_or #(.WIDTH(irq_pending_pkg::N_DMA)) u_dma (
		.status_i(src_i.dma),
		.request_o(dma_request_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_SSP)) u_ssp (
		.status_i(src_i.sync_serial_port),
		.request_o(sync_serial_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_CARD)) u_card (
		.status_i(src_i.card),
		.request_o(card_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_FULL_FUNCTION_UART)) u_full_function_uart (
		.status_i(src_i.full_function_uart),
		.request_o(fullfunc_uart_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_BLUETOOTH_UART)) u_bluetooth_uart (
		.status_i(src_i.bluetooth_uart),
		.request_o(bt_uart_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_STANDARD_UART)) u_standard_uart (
		.status_i(src_i.standard_uart),
		.request_o(standard_uart_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_INFRARED)) u_infrared (
		.status_i(src_i.infrared),
		.request_o(infrared_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_TWO_WIRE)) u_two_wire (
		.status_i(src_i.two_wire),
		.request_o(two_wire_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_DISPLAY)) u_display (
		.status_i(src_i.display),
		.request_o(display_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_AUDIO)) u_audio (
		.status_i(src_i.audio),
		.request_o(audio_codec_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_SOUND)) u_sound (
		.status_i(src_i.sound),
		.request_o(sound_serial_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_USB)) u_usb (
		.status_i(src_i.usb),
		.request_o(usb_pending)
	);
	unit_request_or #(.WIDTH(irq_pending_pkg::N_UPPER_PINS)) u_upper_pins (
		.status_i(src_i.upper_pins),
		.request_o(upper_pins_edge_pending)
	);

	// bit placement; no mask input exists, so masking cannot hide a request
	always_comb begin
		raw_pending_reg_d = irq_pending_pkg::RAW_PENDING_RESET; // reserved bits stay zero
		raw_pending_reg_d[irq_pending_pkg::BIT_ALARM] = src_i.alarm;
		raw_pending_reg_d[irq_pending_pkg::BIT_TICK] = src_i.tick;
		raw_pending_reg_d[irq_pending_pkg::BIT_TIMER0 +: irq_pending_pkg::N_TIMER] =
			src_i.timer_match;
		raw_pending_reg_d[irq_pending_pkg::BIT_DMA] = dma_request_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_SSP] = sync_serial_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_CARD] = card_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_FULL_FUNCTION_UART] = fullfunc_uart_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_BLUETOOTH_UART] = bt_uart_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_STANDARD_UART] = standard_uart_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_INFRARED] = infrared_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_TWO_WIRE] = two_wire_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_DISPLAY] = display_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_AUDIO] = audio_codec_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_SOUND] = sound_serial_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_PERF] = src_i.perf;
		raw_pending_reg_d[irq_pending_pkg::BIT_USB] = usb_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_UPPER_PINS] = upper_pins_edge_pending;
		raw_pending_reg_d[irq_pending_pkg::BIT_PIN1] = src_i.pin1;
		raw_pending_reg_d[irq_pending_pkg::BIT_PIN0] = src_i.pin0;
	end

	// level follower: a bit drops only once its unit's status is all clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_pending_reg_q <= irq_pending_pkg::RAW_PENDING_RESET;
		end else begin
			raw_pending_reg_q <= raw_pending_reg_d;
		end
	end

	// wishbone slave: one-cycle-late ack, writes ignored (read-only register)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_q <= 1'b0;
		end else begin
			wb_ack_q <= wb_req_i.cyc & wb_req_i.stb & ~wb_ack_q;
		end
	end

	// read data; writes to reserved bits are dropped, so zeros are harmless
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_q <= irq_pending_pkg::UNMAPPED_READ;
		end else if (wb_req_i.cyc & wb_req_i.stb & ~wb_ack_q & ~wb_req_i.we) begin
			if (wb_req_i.adr == irq_pending_pkg::RAW_PENDING_ADDR) begin
				wb_dat_q <= raw_pending_reg_q;
			end else begin
				wb_dat_q <= irq_pending_pkg::UNMAPPED_READ;
			end
		end
	end

	assign wb_ack_o = wb_ack_q;
	assign wb_dat_o = wb_dat_q;
	assign raw_pending_reg_o = raw_pending_reg_q;

	// a unit request shows exactly one clock later
	a_dma_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		(|src_i.dma) |=> raw_pending_reg_q[irq_pending_pkg::BIT_DMA])
		else $error("dma pending missed");
	a_dma_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.dma) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_DMA])
		else $error("dma pending stuck");
	// one channel leaving while another stays must not drop the unit's bit
	sequence s_dma_handover;
		(|src_i.dma) ##1 (|src_i.dma) && $changed(src_i.dma);
	endsequence
	a_dma_handover: assert property (@(posedge clk_i) disable iff (rst_i)
		s_dma_handover |=> raw_pending_reg_q[irq_pending_pkg::BIT_DMA])
		else $error("dma pending dropped on handover");

	// copied bits match last edge's lines; the edge after reset is skipped
	// since lines may already be up while the register still reads zero
	a_alarm_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_ALARM] == $past(src_i.alarm))
		else $error("alarm bit wrong");
	a_alarm_tick: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_TICK] == $past(src_i.tick))
		else $error("tick bit wrong");
	a_timer_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> raw_pending_reg_q[irq_pending_pkg::BIT_TIMER0 +:
		irq_pending_pkg::N_TIMER] == $past(src_i.timer_match))
		else $error("timer bits wrong");
	a_ssp_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_SSP] == $past(|src_i.sync_serial_port))
		else $error("ssp bit wrong");
	a_card_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_CARD] == $past(|src_i.card))
		else $error("card bit wrong");
	a_uart_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> raw_pending_reg_q[irq_pending_pkg::BIT_FULL_FUNCTION_UART:irq_pending_pkg::BIT_STANDARD_UART]
		== $past({|src_i.full_function_uart, |src_i.bluetooth_uart, |src_i.standard_uart}))
		else $error("uart bits wrong");
	a_infrared_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_INFRARED] == $past(|src_i.infrared))
		else $error("infrared bit wrong");
	a_two_wire_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_TWO_WIRE] == $past(|src_i.two_wire))
		else $error("two-wire bit wrong");
	a_display_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_DISPLAY] == $past(|src_i.display))
		else $error("display bit wrong");
	a_audio_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_AUDIO] == $past(|src_i.audio))
		else $error("audio bit wrong");
	a_sound_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_SOUND] == $past(|src_i.sound))
		else $error("sound bit wrong");
	a_perf_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_PERF] == $past(src_i.perf))
		else $error("perf bit wrong");
	a_usb_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_USB] == $past(|src_i.usb))
		else $error("usb bit wrong");
	a_upper_pins_or: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i)
		|-> raw_pending_reg_q[irq_pending_pkg::BIT_UPPER_PINS] == $past(|src_i.upper_pins))
		else $error("pin edge or wrong");
	a_pins_single: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> {raw_pending_reg_q[irq_pending_pkg::BIT_PIN1],
		raw_pending_reg_q[irq_pending_pkg::BIT_PIN0]} == $past({src_i.pin1, src_i.pin0}))
		else $error("pin bits wrong");

	// no mask reaches this block: any live line must show somewhere
	a_any_request: assert property (@(posedge clk_i) disable iff (rst_i)
		(|src_i) |=> (|raw_pending_reg_q))
		else $error("live request hidden");
	a_ssp_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.sync_serial_port) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_SSP])
		else $error("ssp pending stuck");
	a_card_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.card) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_CARD])
		else $error("card pending stuck");
	a_display_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.display) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_DISPLAY])
		else $error("display pending stuck");
	a_sound_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.sound) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_SOUND])
		else $error("sound pending stuck");
	a_usb_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.usb) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_USB])
		else $error("usb pending stuck");
	a_upper_pins_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		!(|src_i.upper_pins) |=> !raw_pending_reg_q[irq_pending_pkg::BIT_UPPER_PINS])
		else $error("pin edge pending stuck");
	// reset guard keeps the unknown power-up value out of this check
	a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(raw_pending_reg_q & irq_pending_pkg::RESERVED_BITS) == '0)
		else $error("reserved bits set");
	a_reset_clear: assert property (@(posedge clk_i)
		rst_i |=> raw_pending_reg_q == irq_pending_pkg::RAW_PENDING_RESET)
		else $error("not clear after reset");
	a_reset_outputs: assert property (@(posedge clk_i)
		rst_i |=> !wb_ack_o && wb_dat_o == irq_pending_pkg::UNMAPPED_READ)
		else $error("bus outputs not idle after reset");

	// bus side: answer one cycle after the taking edge, writes acked and dropped
	sequence s_read_req;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_q && !wb_req_i.we
			&& wb_req_i.adr == irq_pending_pkg::RAW_PENDING_ADDR;
	endsequence
	sequence s_other_read;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_q && !wb_req_i.we
			&& wb_req_i.adr != irq_pending_pkg::RAW_PENDING_ADDR;
	endsequence
	sequence s_write_req;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_q && wb_req_i.we;
	endsequence
	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_req |=> wb_ack_o && wb_dat_o == $past(raw_pending_reg_q))
		else $error("read data wrong");
	a_other_read: assert property (@(posedge clk_i) disable iff (rst_i)
		s_other_read |=> wb_ack_o && wb_dat_o == irq_pending_pkg::UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_write_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
		s_write_req |=> wb_ack_o && $stable(wb_dat_o))
		else $error("write not acked or disturbed data");
	a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");

endmodule : irq_pending_map
`default_nettype wire

//--- periph_status_model.sv
// peripheral units model: second-level status lines behind each pending bit
`timescale 1ns/1ps
`default_nettype none
module periph_status_model #(
	parameter int NSRC = 179
) (
	input wire logic clk_i,
	input wire logic [NSRC-1:0] set_i,
	input wire logic [NSRC-1:0] clr_i,
	output var irq_pending_pkg::source_lines_type src_o
);
	logic [NSRC-1:0] stat_q = '0;
	// a status line stays up until software clears it at its unit; set wins a tie
	always_ff @(posedge clk_i) begin
		stat_q <= (stat_q & ~clr_i) | set_i;
	end
	assign src_o = irq_pending_pkg::source_lines_type'(stat_q);
endmodule : periph_status_model
`default_nettype wire

//--- interrupt_pending_source_map_tb.sv
// self-checking bench for the raw pending register and its bus slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module interrupt_pending_source_map_tb;
	localparam int NSRC = $bits(irq_pending_pkg::source_lines_type);
	localparam logic [31:0] ADR = irq_pending_pkg::RAW_PENDING_ADDR;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic live = 1'b0;
	irq_pending_pkg::wb_req_type req = '0;
	irq_pending_pkg::source_lines_type src, u;
	logic [31:0] wb_dat_o, raw_o, rd;
	logic [31:0] exp_q = '0;
	logic [31:0] seed = 32'h65c82139;
	logic wb_ack_o;
	logic [NSRC-1:0] set_v = '0, clr_v = '0, src_m = '0;
	int err_total = 0, comparisons = 0;

	always #2.5 clk_i = ~clk_i;

	irq_pending_map irq_pending_map_inst (.clk_i(clk_i), .rst_i(rst_i), .src_i(src),
		.wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .raw_pending_reg_o(raw_o));
	periph_status_model #(.NSRC(NSRC)) periph_status_model_inst (.clk_i(clk_i),
		.set_i(set_v), .clr_i(clr_v), .src_o(src));

	// reference map: each unit's lines or-ed into its fixed bit, timer matches one bit each, reserved bits zero
	function automatic logic [31:0] map_src(input logic [NSRC-1:0] v);
		irq_pending_pkg::source_lines_type s;
		logic [31:0] p;
		s = irq_pending_pkg::source_lines_type'(v);
		p = 32'h0;
		p[31] = s.alarm;
		p[30] = s.tick;
		p[29:26] = s.timer_match;
		p[25] = |s.dma;
		p[24] = |s.sync_serial_port;
		p[23] = |s.card;
		p[22] = |s.full_function_uart;
		p[21] = |s.bluetooth_uart;
		p[20] = |s.standard_uart;
		p[19] = |s.infrared;
		p[18] = |s.two_wire;
		p[17] = |s.display;
		p[14] = |s.audio;
		p[13] = |s.sound;
		p[12] = s.perf;
		p[11] = |s.usb;
		p[10] = |s.upper_pins;
		p[9] = s.pin1;
		p[8] = s.pin0;
		return p;
	endfunction : map_src

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic summarize();
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// one classic cycle; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d, sel: 4'hf};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			err_total++;
			summarize();
		end
		q = wb_dat_o;
		req <= '0;
		@(posedge clk_i);
	endtask : wb

	// one-cycle set/clear command to the units, then let the bit settle
	task automatic pulse(input logic [NSRC-1:0] s, input logic [NSRC-1:0] c);
		set_v <= s;
		clr_v <= c;
		src_m = (src_m & ~c) | s;
		@(posedge clk_i);
		set_v <= '0;
		clr_v <= '0;
		repeat (2) @(posedge clk_i);
	endtask : pulse

	// handler flow: read pending, then the unit would be asked for its source
	task automatic rdchk();
		wb(1'b0, ADR, 32'h0, rd);
		`CHK(rd, map_src(src_m))
	endtask : rdchk

	// every edge: pending equals last edge's lines, zero while in reset
	always @(posedge clk_i) begin
		if (live) `CHK(raw_o, exp_q)
		exp_q = rst_i ? 32'h0 : map_src(src);
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		live = 1'b1;
		wb(1'b0, ADR, 32'h0, rd);
		`CHK(rd, 32'h0)
		wb(1'b0, ADR + 32'h4, 32'h0, rd);
		`CHK(rd, 32'h0)
		// all lines up; writes with reserved bits zero must not disturb it
		pulse('1, '0);
		wb(1'b1, ADR, xs() & 32'hfffe7f00, rd);
		rdchk();
		// unmapped word must stay zero even while every line is up
		wb(1'b0, ADR + 32'h4, 32'h0, rd);
		`CHK(rd, 32'h0)
		`CHK(raw_o, 32'hfffe7f00)
		pulse('0, '1);
		// walk every line on its own
		for (int i = 0; i < NSRC; i++) begin
			pulse(NSRC'(1) << i, '0);
			rdchk();
			pulse('0, NSRC'(1) << i);
		end
		// two channels of one unit: bit holds until the last clears
		u = '0;
		u.dma[3] = 1'b1;
		u.dma[9] = 1'b1;
		pulse(u, '0);
		u.dma[9] = 1'b0;
		pulse('0, u);
		`CHK(raw_o[25], 1'b1)
		pulse('0, '1);
		`CHK(raw_o[25], 1'b0)
		repeat (60) begin
			pulse(NSRC'({xs(), xs(), xs(), xs(), xs(), xs()}), NSRC'({xs(), xs(), xs(), xs(), xs(), xs()}));
			rdchk();
		end
		// reset in mid-run with lines still active
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rdchk();
		summarize();
	end
endmodule : interrupt_pending_source_map_tb
`default_nettype wire
